//--- pwmcc_pkg.sv
// Package for the six-channel PWM channel counter core.
// Holds the register map, reset values, channel layout and the per-tick step function.
// Assumes a 32-bit APB slave with byte-wide channel registers in the low data bits.
`default_nettype none

package pwmcc_pkg;

  // ----------------------------------------------------------------------
  // Channel layout
  // ----------------------------------------------------------------------
  localparam int CH_NUM   = 6;
  localparam int PAIR_NUM = 3;
  localparam int CW       = 8;
  localparam int DW       = 16;

  // Channels that take clock B / scaled B instead of clock A / scaled A.
  localparam logic [CH_NUM-1:0] B_CLK_MASK = 6'h0c;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] RUN_OFS    = 8'h00;
  localparam logic [7:0] LEVEL_OFS  = 8'h04;
  localparam logic [7:0] CLKSEL_OFS = 8'h08;
  localparam logic [7:0] ALIGN_OFS  = 8'h0c;
  localparam logic [7:0] CTRL_OFS   = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;

  // Per-channel banks: byte address = bank * 0x20 + 4 * channel.
  localparam logic [2:0] CNT_BANK  = 3'h1;
  localparam logic [2:0] PER_BANK  = 3'h2;
  localparam logic [2:0] DUTY_BANK = 3'h3;

  // Status register field positions.
  localparam int STAT_DIR_LSB = 0;
  localparam int STAT_OUT_LSB = 8;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [CW-1:0]       CNT_RST  = 8'h00;
  localparam logic [CW-1:0]       PER_RST  = 8'hff;
  localparam logic [CW-1:0]       DUTY_RST = 8'h00;
  localparam logic [CH_NUM-1:0]   BITS_RST = 6'h00;
  localparam logic [PAIR_NUM-1:0] JOIN_RST = 3'h0;
  localparam logic [DW-1:0]       ZERO16   = 16'h0000;
  localparam logic [DW-1:0]       ONE16    = 16'h0001;

  localparam logic DIR_UP   = 1'b0;
  localparam logic DIR_DOWN = 1'b1;

  // ----------------------------------------------------------------------
  // Step of one counter unit on a selected clock tick
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [DW-1:0] cnt;
    logic          dir;
    logic          ff;
    logic          load;
  } pwmcc_step_type;

  // Works on 16 bits; an unjoined 8-bit channel passes zero-extended values.
  function automatic pwmcc_step_type pwmcc_step(
    input logic [DW-1:0] cnt,
    input logic [DW-1:0] per,
    input logic [DW-1:0] dty,
    input logic          dir,
    input logic          ff,
    input logic          center
  );
    pwmcc_step_type r;
    logic [DW-1:0]  n;
    logic           d;
    r = '{cnt: cnt, dir: dir, ff: ff, load: 1'b0};
    n = cnt;
    d = dir;
    if (!center) begin
      n = cnt + ONE16;
      if (n == per) begin
        r.cnt  = ZERO16;
        r.ff   = 1'b0;
        r.load = 1'b1;
        r.dir  = DIR_UP;
      end else begin
        r.cnt = n;
        r.dir = DIR_UP;
        if (n == dty) begin
          r.ff = ~ff;
        end
      end
    end else begin
      if (cnt == ZERO16) begin
        d = DIR_UP;
      end
      if (d == DIR_UP) begin
        n     = cnt + ONE16;
        r.dir = (n == per) ? DIR_DOWN : DIR_UP;
      end else begin
        n     = cnt - ONE16;
        r.dir = DIR_DOWN;
        if (n == ZERO16) begin
          r.dir  = DIR_UP;
          r.load = 1'b1;
        end
      end
      r.cnt = n;
      if (n == dty) begin
        r.ff = ~ff;
      end
    end
    return r;
  endfunction : pwmcc_step

endpackage : pwmcc_pkg

`default_nettype wire

//--- pwmcc_core.sv
// Six-channel 8-bit PWM counter core with pair joining into 16-bit channels.
// Assumes an APB master on pclk and per-rate tick enables from a prescaler on the same clock.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`default_nettype none
`timescale 1ns/1ps

module pwmcc_core
  import pwmcc_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // Clock source enables, one pclk cycle each
  input  wire logic              tick_a,
  input  wire logic              tick_sa,
  input  wire logic              tick_b,
  input  wire logic              tick_sb,
  // Waveform pins
  output var  logic [CH_NUM-1:0] wave_out,
  output var  logic [CH_NUM-1:0] wave_oe
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [CW-1:0]       channel_count_value [CH_NUM];
  logic [CW-1:0]       period_value        [CH_NUM];
  logic [CW-1:0]       duty_value          [CH_NUM];
  logic [CW-1:0]       period_active       [CH_NUM];
  logic [CW-1:0]       duty_active         [CH_NUM];
  logic [CH_NUM-1:0]   channel_run_bit;
  logic [CH_NUM-1:0]   start_level_select;
  logic [CH_NUM-1:0]   scaled_clock_select;
  logic [CH_NUM-1:0]   center_align_select;
  logic [PAIR_NUM-1:0] wave_control_reg;
  logic [CH_NUM-1:0]   count_dir;
  logic [CH_NUM-1:0]   out_flop;
  logic [CH_NUM-1:0]   run_synced;
  logic [CH_NUM-1:0]   zero_period_pending;

  logic                join_pair_ch0_ch1;
  logic                join_pair_ch2_ch3;
  logic                join_pair_ch4_ch5;

  assign join_pair_ch0_ch1 = wave_control_reg[0];
  assign join_pair_ch2_ch3 = wave_control_reg[1];
  assign join_pair_ch4_ch5 = wave_control_reg[2];

  // Join bits gathered by pair index, lowest pair in bit 0.
  logic [PAIR_NUM-1:0] pair_joined;
  assign pair_joined = {join_pair_ch4_ch5, join_pair_ch2_ch3, join_pair_ch0_ch1};

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic              access;
  logic              wr_en;
  logic [2:0]        bank;
  logic [2:0]        slot;
  logic              slot_ok;
  logic [CH_NUM-1:0] cnt_wr;
  logic [CH_NUM-1:0] per_wr;
  logic [CH_NUM-1:0] duty_wr;
  logic [CW-1:0]     wbyte;

  assign access  = psel & penable & pready;
  assign wr_en   = access & pwrite;
  assign bank    = paddr[7:5];
  assign slot    = paddr[4:2];
  assign slot_ok = (paddr[1:0] == 2'h0) && (32'(slot) < CH_NUM);
  assign wbyte   = pwdata[CW-1:0];

  always_comb begin
    for (int ch = 0; ch < CH_NUM; ch++) begin
      cnt_wr[ch]  = wr_en && slot_ok && bank == CNT_BANK  && 32'(slot) == ch;
      per_wr[ch]  = wr_en && slot_ok && bank == PER_BANK  && 32'(slot) == ch;
      duty_wr[ch] = wr_en && slot_ok && bank == DUTY_BANK && 32'(slot) == ch;
    end
  end

  // ----------------------------------------------------------------------
  // Per-channel next state
  // ----------------------------------------------------------------------
  logic [CW-1:0]     next_cnt [CH_NUM];
  logic [CH_NUM-1:0] next_dir;
  logic [CH_NUM-1:0] next_ff;
  logic [CH_NUM-1:0] next_load;
  logic [CH_NUM-1:0] next_zclr;
  logic [CH_NUM-1:0] owner_run;
  logic [CH_NUM-1:0] owner_tick;
  logic [CH_NUM-1:0] is_high_joined;
  logic [CH_NUM-1:0] owner_level;

  always_comb begin
    int             own;
    int             lo;
    int             hi;
    logic           j;
    logic           cw;
    logic           zp;
    logic           tk;
    logic [DW-1:0]  c16;
    logic [DW-1:0]  p16;
    logic [DW-1:0]  d16;
    pwmcc_step_type r;
    own = 0;
    lo  = 0;
    hi  = 0;
    j   = 1'b0;
    cw  = 1'b0;
    zp  = 1'b0;
    tk  = 1'b0;
    c16 = ZERO16;
    p16 = ZERO16;
    d16 = ZERO16;
    r   = '{cnt: ZERO16, dir: DIR_UP, ff: 1'b0, load: 1'b0};
    for (int ch = 0; ch < CH_NUM; ch++) begin
      lo  = ch | 1;
      hi  = ch & ~1;
      j   = pair_joined[ch / 2];
      own = j ? lo : ch;
      // A write to either byte of a joined counter clears the whole 16-bit count.
      if (j) begin
        c16 = {channel_count_value[hi], channel_count_value[lo]};
        p16 = {period_active[hi], period_active[lo]};
        d16 = {duty_active[hi], duty_active[lo]};
        cw  = cnt_wr[hi] | cnt_wr[lo];
        zp  = zero_period_pending[hi] | zero_period_pending[lo];
      end else begin
        c16 = {8'h00, channel_count_value[ch]};
        p16 = {8'h00, period_active[ch]};
        d16 = {8'h00, duty_active[ch]};
        cw  = cnt_wr[ch];
        zp  = zero_period_pending[ch];
      end
      if (B_CLK_MASK[own]) begin
        tk = scaled_clock_select[own] ? tick_sb : tick_b;
      end else begin
        tk = scaled_clock_select[own] ? tick_sa : tick_a;
      end
      owner_tick[ch]     = tk;
      owner_run[ch]      = channel_run_bit[own];
      owner_level[ch]    = start_level_select[own];
      is_high_joined[ch] = j && (ch == hi);
      next_zclr[ch]      = 1'b0;
      r = '{cnt: c16, dir: count_dir[own], ff: out_flop[own], load: 1'b0};
      if (cw) begin
        r = '{cnt: ZERO16, dir: DIR_UP, ff: 1'b0, load: 1'b1};
      end else if (tk && run_synced[own]) begin
        r = pwmcc_step(c16, p16, d16, count_dir[own], out_flop[own],
                       center_align_select[own]);
      end else if (tk && zp && !channel_run_bit[own]) begin
        r.cnt         = ZERO16;
        next_zclr[ch] = 1'b1;
      end
      next_cnt[ch]  = is_high_joined[ch] ? r.cnt[DW-1:CW] : r.cnt[CW-1:0];
      next_dir[ch]  = r.dir;
      next_ff[ch]   = r.ff;
      next_load[ch] = r.load;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_run_bit     <= BITS_RST;
      start_level_select  <= BITS_RST;
      scaled_clock_select <= BITS_RST;
      center_align_select <= BITS_RST;
      wave_control_reg    <= JOIN_RST;
    end else if (wr_en) begin
      unique case (paddr)
        RUN_OFS:    channel_run_bit     <= pwdata[CH_NUM-1:0];
        LEVEL_OFS:  start_level_select  <= pwdata[CH_NUM-1:0];
        CLKSEL_OFS: scaled_clock_select <= pwdata[CH_NUM-1:0];
        ALIGN_OFS:  center_align_select <= pwdata[CH_NUM-1:0];
        CTRL_OFS:   wave_control_reg    <= pwdata[PAIR_NUM-1:0];
        default:    ;
      endcase
    end
  end

  // Buffered period and duty, written whatever the run state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int ch = 0; ch < CH_NUM; ch++) begin
        period_value[ch] <= PER_RST;
        duty_value[ch]   <= DUTY_RST;
      end
    end else begin
      for (int ch = 0; ch < CH_NUM; ch++) begin
        if (per_wr[ch]) begin
          period_value[ch] <= wbyte;
        end
        if (duty_wr[ch]) begin
          duty_value[ch] <= wbyte;
        end
      end
    end
  end

  // Active period and duty: loaded at period end or counter write, or directly while disabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int ch = 0; ch < CH_NUM; ch++) begin
        period_active[ch] <= PER_RST;
        duty_active[ch]   <= DUTY_RST;
      end
    end else begin
      for (int ch = 0; ch < CH_NUM; ch++) begin
        if (per_wr[ch] && !owner_run[ch]) begin
          period_active[ch] <= wbyte;
        end else if (next_load[ch]) begin
          period_active[ch] <= period_value[ch];
        end
        if (duty_wr[ch] && !owner_run[ch]) begin
          duty_active[ch] <= wbyte;
        end else if (next_load[ch]) begin
          duty_active[ch] <= duty_value[ch];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Channel timers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int ch = 0; ch < CH_NUM; ch++) begin
        channel_count_value[ch] <= CNT_RST;
      end
      count_dir <= {CH_NUM{DIR_UP}};
      out_flop  <= BITS_RST;
    end else begin
      for (int ch = 0; ch < CH_NUM; ch++) begin
        channel_count_value[ch] <= next_cnt[ch];
      end
      count_dir <= next_dir;
      out_flop  <= next_ff;
    end
  end

  // Run bit is taken into the counter only on a tick of the selected clock.
  // Clearing it also waits for a tick, so one more step may follow a disable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_synced <= BITS_RST;
    end else begin
      for (int ch = 0; ch < CH_NUM; ch++) begin
        if (owner_tick[ch]) begin
          run_synced[ch] <= channel_run_bit[ch];
        end
      end
    end
  end

  // A new zero-period request wins over the clearing of an older one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_period_pending <= BITS_RST;
    end else begin
      for (int ch = 0; ch < CH_NUM; ch++) begin
        if (per_wr[ch] && wbyte == CNT_RST && !owner_run[ch]) begin
          zero_period_pending[ch] <= 1'b1;
        end else if (next_zclr[ch]) begin
          zero_period_pending[ch] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_out <= BITS_RST;
      wave_oe  <= BITS_RST;
    end else begin
      for (int ch = 0; ch < CH_NUM; ch++) begin
        wave_out[ch] <= owner_level[ch] ? ~next_ff[ch] : next_ff[ch];
        wave_oe[ch]  <= owner_run[ch] & ~is_high_joined[ch];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read path and APB answer
  // ----------------------------------------------------------------------
  logic [31:0] rd_data;
  logic        rd_hit;

  // A read only selects a value; no counter, flop or flag moves on a read.
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (slot_ok && bank == CNT_BANK) begin
      rd_data[CW-1:0] = channel_count_value[slot];
    end else if (slot_ok && bank == PER_BANK) begin
      rd_data[CW-1:0] = period_value[slot];
    end else if (slot_ok && bank == DUTY_BANK) begin
      rd_data[CW-1:0] = duty_value[slot];
    end else begin
      unique case (paddr)
        RUN_OFS:    rd_data[CH_NUM-1:0]   = channel_run_bit;
        LEVEL_OFS:  rd_data[CH_NUM-1:0]   = start_level_select;
        CLKSEL_OFS: rd_data[CH_NUM-1:0]   = scaled_clock_select;
        ALIGN_OFS:  rd_data[CH_NUM-1:0]   = center_align_select;
        CTRL_OFS:   rd_data[PAIR_NUM-1:0] = wave_control_reg;
        STATUS_OFS: begin
          rd_data[STAT_DIR_LSB +: CH_NUM] = count_dir;
          rd_data[STAT_OUT_LSB +: CH_NUM] = wave_out;
        end
        default:    rd_hit = 1'b0;
      endcase
    end
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~rd_hit;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rd_data;
      end
    end
  end

endmodule : pwmcc_core

`default_nettype wire

//--- pwmcc_core_properties.sv
// Concurrent checks on the ports of the PWM channel counter core.
// Assumes one pclk domain with an asynchronous active-low presetn; bound to every core.
`timescale 1ns/1ps
`default_nettype none
module pwmcc_core_properties
  import pwmcc_pkg::*;
(
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB slave
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Tick enables
  input wire logic              tick_a,
  input wire logic              tick_sa,
  input wire logic              tick_b,
  input wire logic              tick_sb,
  // Waveform pins
  input wire logic [CH_NUM-1:0] wave_out,
  input wire logic [CH_NUM-1:0] wave_oe
);
  logic wr_done;
  logic cause_any;

  // A pin may only move after a completed write or a clock source tick.
  assign wr_done   = psel && penable && pready && pwrite;
  assign cause_any = wr_done || tick_a || tick_sa || tick_b || tick_sb;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable; endsequence

  ready_wait_a: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
    else $error("pready not in the second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  bad_read_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  rdata_hold_a: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("prdata moved without a read");
  wave_cause_a: assert property ($changed(wave_out) |-> $past(cause_any) || $past(cause_any, 2))
    else $error("waveform moved without tick or write");
  oe_cause_a: assert property ($changed(wave_oe) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("output enable moved without a write");
  reset_quiet_a: assert property ($rose(presetn) |-> wave_out == 6'h00 && wave_oe == 6'h00)
    else $error("pins active right after reset");
endmodule : pwmcc_core_properties

bind pwmcc_core pwmcc_core_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .tick_a, .tick_sa, .tick_b, .tick_sb, .wave_out, .wave_oe);
`default_nettype wire

//--- pwmcc_core_tb.sv
// Self-checking bench for the PWM channel counter core.
// Drives APB and the four tick enables itself; ticks: A every 2, SA every 8, B every 2, SB every 16 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module pwmcc_core_tb
  import pwmcc_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic              tick_a, tick_sa, tick_b, tick_sb;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, q;
  logic [3:0]        cyc;
  logic [CH_NUM-1:0] wave_out, wave_oe;
  int                mismatches = 0, compares = 0, hi, lo;

  pwmcc_core DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tick_a, .tick_sa, .tick_b, .tick_sb, .wave_out, .wave_oe);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 4'h1;
    tick_a <= cyc[0];
    tick_sa <= (cyc[2:0] == 3'h7);
    tick_b <= ~cyc[0];
    tick_sb <= (cyc == 4'h5);
  end

  function automatic logic [7:0] adr(input logic [2:0] b, input int ch);
    return {b, ch[2:0], 2'b00};
  endfunction : adr

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(a, 1'b0, 32'h0);
    `CHK(nm, e, q)
  endtask : rd

  // Counts cycles while a pin holds one level, bounded.
  task automatic stay(input int ch, input logic v, output int c);
    c = 0;
    while (wave_out[ch] === v && c < 5000) begin
      @(posedge pclk);
      c++;
    end
    if (c == 5000) mismatches++;
  endtask : stay

  task automatic setup(input int ch, input logic [5:0] lvl, sel, aln, input logic [7:0] per, dty);
    int c;
    wr(RUN_OFS, 32'h0);
    wr(LEVEL_OFS, {26'h0, lvl});
    wr(CLKSEL_OFS, {26'h0, sel});
    wr(ALIGN_OFS, {26'h0, aln});
    wr(adr(PER_BANK, ch), {24'h0, per});
    wr(adr(DUTY_BANK, ch), {24'h0, dty});
    wr(adr(CNT_BANK, ch), 32'h0);
    wr(RUN_OFS, 32'h1 << ch);
    stay(ch, 1'b1, c);
    stay(ch, 1'b0, c);
    stay(ch, 1'b1, hi);
    stay(ch, 1'b0, lo);
  endtask : setup

  task automatic t_reset();
    `CHK("oe_rst", 6'h00, wave_oe)
    rd(RUN_OFS, 32'h0, "run_rst");
    rd(adr(PER_BANK, 0), 32'hff, "per_rst");
    rd(adr(CNT_BANK, 5), 32'h0, "cnt_rst");
    rd(STATUS_OFS, 32'h0, "status_rst");
    rd(8'hfc, 32'h0, "unmapped");
    `CHK("slverr", 1'b1, er)
  endtask : t_reset

  task automatic t_left();
    setup(0, 6'h00, 6'h00, 6'h00, 8'h04, 8'h01);
    `CHK("left_hi", 6, hi)
    `CHK("left_lo", 2, lo)
    setup(0, 6'h01, 6'h01, 6'h00, 8'h04, 8'h01);
    `CHK("left_hi_pol", 8, hi)
    `CHK("left_lo_pol", 24, lo)
    setup(3, 6'h00, 6'h00, 6'h00, 8'h05, 8'h02);
    `CHK("left_b_hi", 6, hi)
  endtask : t_left

  task automatic t_center();
    setup(1, 6'h00, 6'h00, 6'h02, 8'h04, 8'h01);
    `CHK("ctr_hi", 12, hi)
    `CHK("ctr_lo", 4, lo)
    setup(2, 6'h04, 6'h04, 6'h04, 8'h03, 8'h02);
    `CHK("ctr_sb_hi", 64, hi)
    `CHK("ctr_sb_lo", 32, lo)
  endtask : t_center

  task automatic t_join();
    wr(CTRL_OFS, 32'h1);
    wr(adr(PER_BANK, 0), 32'h1);
    wr(adr(DUTY_BANK, 0), 32'h0);
    setup(1, 6'h02, 6'h00, 6'h00, 8'h10, 8'h80);
    `CHK("join_hi", 256, hi)
    `CHK("join_lo", 288, lo)
    `CHK("join_oe", 6'h02, wave_oe)
    wr(RUN_OFS, 32'h0);
    wr(CTRL_OFS, 32'h0);
  endtask : t_join

  task automatic t_hold();
    logic [31:0] v;
    int c;
    setup(0, 6'h01, 6'h00, 6'h00, 8'hc8, 8'h64);
    wr(RUN_OFS, 32'h0);
    rd(RUN_OFS, 32'h0, "run_off");
    v = q;
    apb(adr(CNT_BANK, 0), 1'b0, 32'h0);
    v = q;
    rd(adr(CNT_BANK, 0), v, "cnt_held");
    wr(RUN_OFS, 32'h1);
    repeat (8) @(posedge pclk);
    `CHK("run_oe", 1'b1, wave_oe[0])
    apb(adr(CNT_BANK, 0), 1'b0, 32'h0);
    `CHK("resumed", 1'b1, q[7:0] != v[7:0])
    stay(0, 1'b1, c);
    wr(adr(CNT_BANK, 0), 32'h5a);
    repeat (2) @(posedge pclk);
    `CHK("restart_out", 1'b1, wave_out[0])
    stay(0, 1'b1, c);
    wr(RUN_OFS, 32'h0);
    wr(adr(CNT_BANK, 0), 32'h33);
    rd(adr(CNT_BANK, 0), 32'h0, "cnt_clear");
    `CHK("clear_out", 1'b1, wave_out[0])
    wr(RUN_OFS, 32'h1);
    repeat (20) @(posedge pclk);
    wr(RUN_OFS, 32'h0);
    wr(adr(PER_BANK, 0), 32'h0);
    repeat (4) @(posedge pclk);
    rd(adr(CNT_BANK, 0), 32'h0, "zero_per");
  endtask : t_hold

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    #200000;
    mismatches++;
    close_out();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cyc = 4'h0;
    {tick_a, tick_sa, tick_b, tick_sb} = 4'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_left();
    t_center();
    t_join();
    t_hold();
    close_out();
  end
endmodule : pwmcc_core_tb
`default_nettype wire
